// file: rtl/fer_rx_path.sv
// Receive path: three-level line decision to NRZI, NRZ, 5-bit symbols and
// descrambled symbols, with sync hold timer and its register port.
// Assumes the line level arrives already clocked by the recovered clock rx_clk,
// and that the register master runs on clk.
//
// Added by the designer: strobed register access and the register addresses.
`timescale 1ns/1ps

module fer_rx_path #(
  parameter int unsigned HOLD_SHORT_CYC = fer_pkg::HOLD_SHORT_CYC,
  parameter int unsigned HOLD_LONG_CYC = fer_pkg::HOLD_LONG_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic rx_clk,
  input wire logic [1:0] line_level,
  input wire fer_pkg::fer_bus_t bus,
  output logic [fer_pkg::DATA_W-1:0] rd_data,
  output logic [1:0] equalizer_mode_select,
  output logic crs,
  output fer_pkg::fer_sym_t sym,
  output logic sym_valid,
  output logic dscr_sync
);

  // Line-domain state, all on the recovered clock
  typedef struct packed {
    logic [1:0] lvl_m;
    logic [1:0] lvl_s;
    logic [1:0] lvl_prev;
    logic nrzi;
    logic nrzi_prev;
    logic [fer_pkg::SYM_W-1:0] shift;
    logic [2:0] bitcnt;
    logic [fer_pkg::KEY_W-1:0] key;
    fer_pkg::fer_dstate_t dstate;
    logic [3:0] idle_cnt;
    fer_pkg::fer_sym_t sym_hold;
    logic sym_tgl;
    logic idle_tgl;
    logic sync;
    logic [7:0] quiet_cnt;
    logic [7:0] on_cnt;
    logic sd;
    logic [1:0] byp_m;
    logic [1:0] byp_s;
    logic drop_m;
    logic drop_s;
    logic drop_seen;
  } fer_link_st_t;

  // System-domain state, registers and hold timer
  typedef struct packed {
    logic tmr_long;
    logic tmr_dis;
    logic [1:0] eq_mode;
    logic symbol_mode;
    logic dscr_byp;
    logic rx_byp;
    logic [fer_pkg::DATA_W-1:0] rdata;
    logic sync_m;
    logic sync_s;
    logic sync_prev;
    logic sd_m;
    logic sd_s;
    logic sym_tgl_m;
    logic sym_tgl_s;
    logic sym_tgl_seen;
    logic idle_tgl_m;
    logic idle_tgl_s;
    logic idle_tgl_seen;
    logic [fer_pkg::TMR_W-1:0] tmr_cnt;
    logic tmr_run;
    logic drop_tgl;
    fer_pkg::fer_sym_t sym;
    logic sym_valid;
    logic crs;
  } fer_sys_st_t;

  fer_link_st_t l_q;
  fer_link_st_t l_d;
  fer_sys_st_t c_q;
  fer_sys_st_t c_d;

  logic line_chg;
  logic nrz_bit;
  logic sym_done;
  logic [fer_pkg::SYM_W-1:0] sym_word;
  logic [fer_pkg::KEY_W+fer_pkg::SYM_W-1:0] step;
  logic drop_evt;
  logic emit;
  logic sync_rise;
  logic idle_evt;
  logic tmr_clear;
  logic [fer_pkg::TMR_W-1:0] tmr_period;

  // Advance the key generator over one symbol, first bit in the MSB.
  // In hunt mode the generator loads itself from the inverted line bits,
  // which is the key exactly when the far end is sending scrambled IDLE.
  function automatic logic [fer_pkg::KEY_W+fer_pkg::SYM_W-1:0] scr_step(
    input logic [fer_pkg::KEY_W-1:0] key_in,
    input logic [fer_pkg::SYM_W-1:0] rx,
    input logic self_load
  );
    logic [fer_pkg::KEY_W-1:0] k;
    logic [fer_pkg::SYM_W-1:0] plain;
    logic kb;
    k = key_in;
    plain = '0;
    for (int i = fer_pkg::SYM_W - 1; i >= 0; i--) begin
      kb = k[fer_pkg::KEY_TAP_A] ^ k[fer_pkg::KEY_TAP_B];
      plain[i] = rx[i] ^ kb;
      k = {k[fer_pkg::KEY_W-2:0], self_load ? ~rx[i] : kb};
    end
    return {k, plain};
  endfunction

  // Key half of a step result, carried into the next symbol
  function automatic logic [fer_pkg::KEY_W-1:0] step_key(
    input logic [fer_pkg::KEY_W+fer_pkg::SYM_W-1:0] s
  );
    return s[fer_pkg::KEY_W+fer_pkg::SYM_W-1:fer_pkg::SYM_W];
  endfunction

  // Plain symbol half of a step result
  function automatic logic [fer_pkg::SYM_W-1:0] step_plain(
    input logic [fer_pkg::KEY_W+fer_pkg::SYM_W-1:0] s
  );
    return s[fer_pkg::SYM_W-1:0];
  endfunction

  // Line domain next state
  always_comb begin
    l_d = l_q;
    emit = 1'b0;
    step = '0;
    // Line level is a pin: two flops before any logic looks at it
    l_d.lvl_m = line_level;
    l_d.lvl_s = l_q.lvl_m;
    l_d.lvl_prev = l_q.lvl_s;
    // Bypass bits and the drop toggle come from clk; both change slowly
    // enough that a plain two-flop crossing sees every change
    l_d.byp_m = {c_q.rx_byp, c_q.dscr_byp};
    l_d.byp_s = l_q.byp_m;
    l_d.drop_m = c_q.drop_tgl;
    l_d.drop_s = l_q.drop_m;

    // Any move between the three levels is a one in NRZI
    line_chg = (l_q.lvl_s != l_q.lvl_prev);
    l_d.nrzi = l_q.nrzi ^ line_chg;
    l_d.nrzi_prev = l_q.nrzi;
    nrz_bit = l_q.nrzi ^ l_q.nrzi_prev;

    // Signal detect wants sustained activity; a link pulse is a short
    // burst followed by a long quiet gap, so it never qualifies
    // Trade-off: about two microseconds of delay before a real signal counts
    if (line_chg) begin
      l_d.quiet_cnt = '0;
    end else if (l_q.quiet_cnt != 8'hFF) begin
      l_d.quiet_cnt = l_q.quiet_cnt + 8'h01;
    end
    if (l_q.quiet_cnt >= fer_pkg::SD_GAP_BITS) begin
      l_d.on_cnt = '0;
    end else if (l_q.on_cnt != 8'hFF) begin
      l_d.on_cnt = l_q.on_cnt + 8'h01;
    end
    if (l_q.sd) begin
      l_d.sd = (l_q.quiet_cnt < fer_pkg::SD_OFF_BITS);
    end else begin
      l_d.sd = (l_q.on_cnt >= fer_pkg::SD_ON_BITS);
    end

    // Serial to parallel, five line bits to a symbol
    l_d.shift = {l_q.shift[fer_pkg::SYM_W-2:0], nrz_bit};
    sym_word = l_d.shift;
    sym_done = (l_q.bitcnt == fer_pkg::SYM_LAST_BIT);
    l_d.bitcnt = sym_done ? 3'h0 : l_q.bitcnt + 3'h1;

    // Descrambler, one symbol per step
    if (sym_done) begin
      case (l_q.dstate)
        fer_pkg::DS_HUNT: begin
          step = scr_step(l_q.key, sym_word, 1'b1);
          l_d.key = step_key(step);
          if (step_plain(step) == fer_pkg::IDLE_SYM) begin
            if (l_q.idle_cnt == fer_pkg::SYNC_IDLES - 4'h1) begin
              l_d.dstate = fer_pkg::DS_SYNC;
              l_d.idle_cnt = '0;
            end else begin
              l_d.idle_cnt = l_q.idle_cnt + 4'h1;
            end
          end else begin
            l_d.idle_cnt = '0;
          end
        end
        fer_pkg::DS_SYNC: begin
          step = scr_step(l_q.key, sym_word, 1'b0);
          l_d.key = step_key(step);
          // A full run of IDLEs tells the hold timer the lock is good
          // One toggle per run, so a long IDLE stretch keeps reloading it
          if (step_plain(step) == fer_pkg::IDLE_SYM) begin
            if (l_q.idle_cnt == fer_pkg::REARM_IDLES - 4'h1) begin
              l_d.idle_tgl = ~l_q.idle_tgl;
              l_d.idle_cnt = '0;
            end else begin
              l_d.idle_cnt = l_q.idle_cnt + 4'h1;
            end
          end else begin
            l_d.idle_cnt = '0;
          end
        end
        default: begin
          // Unreachable with two states; falls back to hunting
          l_d.dstate = fer_pkg::DS_HUNT;
          l_d.idle_cnt = '0;
        end
      endcase

      // Steering of each finished symbol; receiver bypass outranks
      // descrambler bypass, and both pass raw NRZ bits untouched
      if (l_q.byp_s[1]) begin
        l_d.sym_hold = '{route: fer_pkg::ROUTE_PCS, data: sym_word};
        emit = 1'b1;
      end else if (l_q.byp_s[0]) begin
        l_d.sym_hold = '{route: fer_pkg::ROUTE_ALIGNER, data: sym_word};
        emit = 1'b1;
      end else if (l_q.dstate == fer_pkg::DS_SYNC) begin
        l_d.sym_hold = '{route: fer_pkg::ROUTE_DESCRAMBLED,
                         data: step_plain(step)};
        emit = 1'b1;
      end
      if (emit) begin
        l_d.sym_tgl = ~l_q.sym_tgl;
      end
    end

    // Timer expiry or lost signal throws the descrambler back to hunting
    // Hunting reloads the key from the line, which is the descrambler reset
    drop_evt = (l_q.drop_s != l_q.drop_seen);
    l_d.drop_seen = l_q.drop_s;
    if (drop_evt || !l_q.sd) begin
      l_d.dstate = fer_pkg::DS_HUNT;
      l_d.idle_cnt = '0;
    end
    l_d.sync = (l_d.dstate == fer_pkg::DS_SYNC);
  end

  // The line side after clock recovery runs on the recovered clock
  // Reset matches the idle pin level, so no false edge follows it
  always_ff @(posedge rx_clk or posedge rst) begin
    if (rst) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  // System domain next state
  always_comb begin
    c_d = c_q;
    tmr_clear = 1'b0;
    // Level and toggle crossings from the line domain
    c_d.sync_m = l_q.sync;
    c_d.sync_s = c_q.sync_m;
    c_d.sync_prev = c_q.sync_s;
    c_d.sd_m = l_q.sd;
    c_d.sd_s = c_q.sd_m;
    c_d.sym_tgl_m = l_q.sym_tgl;
    c_d.sym_tgl_s = c_q.sym_tgl_m;
    c_d.idle_tgl_m = l_q.idle_tgl;
    c_d.idle_tgl_s = c_q.idle_tgl_m;

    // Held symbol is stable for five line bits after its toggle moves
    // The word is read across domains only once its toggle has passed two
    // flops, long before the line side can overwrite it
    c_d.sym_valid = 1'b0;
    if (c_q.sym_tgl_s != c_q.sym_tgl_seen) begin
      c_d.sym_tgl_seen = c_q.sym_tgl_s;
      c_d.sym = l_q.sym_hold;
      c_d.sym_valid = 1'b1;
    end

    // Register writes
    if (bus.wr) begin
      case (bus.addr)
        fer_pkg::ADDR_CODING_CFG: begin
          c_d.tmr_long = bus.wdata[fer_pkg::CFG_TMR_LONG_BIT];
          c_d.tmr_dis = bus.wdata[fer_pkg::CFG_TMR_DIS_BIT];
          tmr_clear = bus.wdata[fer_pkg::CFG_TMR_CLR_BIT];
        end
        fer_pkg::ADDR_PHY_CTRL: begin
          c_d.eq_mode = bus.wdata[fer_pkg::EQ_MSB:fer_pkg::EQ_LSB];
        end
        fer_pkg::ADDR_RX_CTRL: begin
          c_d.symbol_mode = bus.wdata[fer_pkg::CTRL_SYMBOL_BIT];
          c_d.dscr_byp = bus.wdata[fer_pkg::CTRL_DSCR_BYP_BIT];
          c_d.rx_byp = bus.wdata[fer_pkg::CTRL_RX_BYP_BIT];
        end
        default: begin
        end
      endcase
    end

    // Read data stand for the one cycle after the strobe, else zero
    c_d.rdata = '0;
    if (bus.rd) begin
      case (bus.addr)
        fer_pkg::ADDR_CODING_CFG: begin
          c_d.rdata[fer_pkg::CFG_TMR_LONG_BIT] = c_q.tmr_long;
          c_d.rdata[fer_pkg::CFG_TMR_DIS_BIT] = c_q.tmr_dis;
        end
        fer_pkg::ADDR_PHY_CTRL: begin
          c_d.rdata[fer_pkg::EQ_MSB:fer_pkg::EQ_LSB] = c_q.eq_mode;
        end
        fer_pkg::ADDR_RX_CTRL: begin
          c_d.rdata[fer_pkg::CTRL_SYMBOL_BIT] = c_q.symbol_mode;
          c_d.rdata[fer_pkg::CTRL_DSCR_BYP_BIT] = c_q.dscr_byp;
          c_d.rdata[fer_pkg::CTRL_RX_BYP_BIT] = c_q.rx_byp;
        end
        fer_pkg::ADDR_RX_STAT: begin
          c_d.rdata[fer_pkg::STAT_SYNC_BIT] = c_q.sync_s;
          c_d.rdata[fer_pkg::STAT_SD_BIT] = c_q.sd_s;
          c_d.rdata[fer_pkg::STAT_TMR_RUN_BIT] = c_q.tmr_run;
        end
        default: begin
        end
      endcase
    end

    // Hold timer; the period is chosen at each reload
    // A clear write in the cycle of expiry wins: the count is reloaded
    // and no drop is sent, which is what a reset of the counter means
    sync_rise = c_q.sync_s & ~c_q.sync_prev;
    idle_evt = (c_q.idle_tgl_s != c_q.idle_tgl_seen);
    c_d.idle_tgl_seen = c_q.idle_tgl_s;
    tmr_period = c_q.tmr_long ? fer_pkg::TMR_W'(HOLD_LONG_CYC - 1)
                              : fer_pkg::TMR_W'(HOLD_SHORT_CYC - 1);
    if (!c_q.sync_s) begin
      c_d.tmr_run = 1'b0;
      c_d.tmr_cnt = '0;
    end else if (sync_rise || idle_evt || tmr_clear) begin
      c_d.tmr_cnt = tmr_period;
      c_d.tmr_run = 1'b1;
    end else if (c_q.tmr_run && !c_q.tmr_dis) begin
      if (c_q.tmr_cnt == '0) begin
        c_d.drop_tgl = ~c_q.drop_tgl;
        c_d.tmr_run = 1'b0;
      end else begin
        c_d.tmr_cnt = c_q.tmr_cnt - fer_pkg::TMR_W'(1);
      end
    end

    // Carrier sense shows signal detect only in symbol mode
    c_d.crs = c_q.symbol_mode & c_q.sd_s;
  end

  // System domain registers
  // Equalizer mode restarts adaptive; everything else clears
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      c_q <= '0;
      c_q.eq_mode <= fer_pkg::EQ_RESET;
    end else begin
      c_q <= c_d;
    end
  end

  // Outputs straight from flops
  // Status reads use the synchronised copies, never line-side flops
  assign rd_data = c_q.rdata;
  assign equalizer_mode_select = c_q.eq_mode;
  assign crs = c_q.crs;
  assign sym = c_q.sym;
  assign sym_valid = c_q.sym_valid;
  assign dscr_sync = c_q.sync_s;

endmodule

// file: rtl/fer_pkg.sv
// Constants, field layouts and carrier types for the 100 Mb/s receive path.
// Assumes one register master on the system clock and a recovered line clock.
package fer_pkg;

  // Register port geometry and map
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 16;
  localparam logic [ADDR_W-1:0] ADDR_CODING_CFG = 5'h16;
  localparam logic [ADDR_W-1:0] ADDR_PHY_CTRL = 5'h19;
  localparam logic [ADDR_W-1:0] ADDR_RX_CTRL = 5'h1A;
  localparam logic [ADDR_W-1:0] ADDR_RX_STAT = 5'h1B;

  // Field positions
  localparam int unsigned CFG_TMR_CLR_BIT = 13;
  localparam int unsigned CFG_TMR_LONG_BIT = 12;
  localparam int unsigned CFG_TMR_DIS_BIT = 11;
  localparam int unsigned EQ_MSB = 13;
  localparam int unsigned EQ_LSB = 12;
  localparam int unsigned CTRL_SYMBOL_BIT = 0;
  localparam int unsigned CTRL_DSCR_BYP_BIT = 1;
  localparam int unsigned CTRL_RX_BYP_BIT = 2;
  localparam int unsigned STAT_SYNC_BIT = 0;
  localparam int unsigned STAT_SD_BIT = 1;
  localparam int unsigned STAT_TMR_RUN_BIT = 2;

  // Equalizer mode codes and reset value
  localparam logic [1:0] EQ_ADAPTIVE = 2'h0;
  localparam logic [1:0] EQ_OFF = 2'h1;
  localparam logic [1:0] EQ_FIXED_MAX = 2'h2;
  localparam logic [1:0] EQ_RESET = EQ_ADAPTIVE;

  // Symbol and descrambler constants
  localparam int unsigned SYM_W = 5;
  localparam int unsigned KEY_W = 11;
  localparam int unsigned KEY_TAP_A = 10;
  localparam int unsigned KEY_TAP_B = 8;
  localparam logic [2:0] SYM_LAST_BIT = 3'h4;
  localparam logic [SYM_W-1:0] IDLE_SYM = 5'h1F;
  localparam logic [3:0] SYNC_IDLES = 4'hC;
  localparam logic [3:0] REARM_IDLES = 4'hC;

  // Signal detect qualification, in line bit times
  localparam logic [7:0] SD_GAP_BITS = 8'h10;
  localparam logic [7:0] SD_ON_BITS = 8'hFA;
  localparam logic [7:0] SD_OFF_BITS = 8'h80;

  // Hold timer, in its own units and as system clock cycles
  localparam int unsigned CLK_MHZ = 100;
  localparam int unsigned HOLD_SHORT_US = 722;
  localparam int unsigned HOLD_LONG_MS = 2;
  localparam int unsigned HOLD_SHORT_CYC = HOLD_SHORT_US * CLK_MHZ;
  localparam int unsigned HOLD_LONG_CYC = HOLD_LONG_MS * 1000 * CLK_MHZ;
  localparam int unsigned TMR_W = 18;

  // Where a finished symbol is headed
  typedef enum logic [1:0] {
    ROUTE_DESCRAMBLED,
    ROUTE_ALIGNER,
    ROUTE_PCS
  } fer_route_t;

  typedef struct packed {
    fer_route_t route;
    logic [SYM_W-1:0] data;
  } fer_sym_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } fer_bus_t;

  typedef enum logic {
    DS_HUNT,
    DS_SYNC
  } fer_dstate_t;

endpackage

// file: dv/fer_rx_path_chk.sv
// Port-level checks for the receive path.
// Assumes every watched port sits in the clk domain.
`timescale 1ns/1ps
module fer_rx_path_chk #(
  parameter int unsigned HOLD_LONG_CYC = fer_pkg::HOLD_LONG_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire fer_pkg::fer_bus_t bus,
  input wire logic [fer_pkg::DATA_W-1:0] rd_data,
  input wire logic [1:0] equalizer_mode_select,
  input wire logic crs,
  input wire fer_pkg::fer_sym_t sym,
  input wire logic sym_valid,
  input wire logic dscr_sync
);
  logic mode_q;
  logic dis_q;
  logic [19:0] gap_q;
  logic wr_cfg;
  logic wr_eq;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  assign wr_cfg = bus.wr && bus.addr == fer_pkg::ADDR_CODING_CFG;
  assign wr_eq = bus.wr && bus.addr == fer_pkg::ADDR_PHY_CTRL;
  // Shadow of symbol mode and timer disable; cycles since last IDLE while synced
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      mode_q <= 1'b0;
      dis_q <= 1'b0;
      gap_q <= 20'h0;
    end else begin
      if (bus.wr && bus.addr == fer_pkg::ADDR_RX_CTRL) mode_q <= bus.wdata[0];
      if (wr_cfg) dis_q <= bus.wdata[11];
      // Only pure streams are sent, so one IDLE stands for a reload
      if (!dscr_sync || dis_q || (sym_valid && sym.data == fer_pkg::IDLE_SYM) || (wr_cfg && bus.wdata[13]))
        gap_q <= 20'h0;
      else if (gap_q != 20'hFFFFF) gap_q <= gap_q + 20'h1;
    end
  end
  a_rd_idle_zero: assert property (!bus.rd |=> rd_data == 16'h0) else $error("read data outside read slot");
  a_eq_write: assert property (wr_eq |=> equalizer_mode_select == $past(bus.wdata[13:12]))
    else $error("equalizer mode not written");
  a_eq_hold: assert property (!wr_eq |=> $stable(equalizer_mode_select)) else $error("equalizer mode moved");
  a_crs_plain: assert property (!mode_q && $past(!mode_q) |-> !crs)
    else $error("carrier sense outside symbol mode");
  a_sym_synced: assert property (sym_valid && sym.route == fer_pkg::ROUTE_DESCRAMBLED
    |-> dscr_sync || $past(dscr_sync, 4)) else $error("descrambled symbol without sync");
  a_sym_spacing: assert property (sym_valid |=> !sym_valid [*8]) else $error("symbol strobe too close");
  a_sym_held: assert property (!sym_valid |-> $stable(sym)) else $error("symbol changed without strobe");
  a_hold_expiry: assert property (gap_q > HOLD_LONG_CYC + 64 |-> !dscr_sync)
    else $error("sync kept past hold time");
  cover property (sym_valid && dscr_sync);
  cover property ($fell(dscr_sync));
  cover property (crs);
endmodule
bind fer_rx_path fer_rx_path_chk #(.HOLD_LONG_CYC(HOLD_LONG_CYC)) u_chk (.clk(clk), .rst(rst), .bus(bus),
  .rd_data(rd_data), .equalizer_mode_select(equalizer_mode_select), .crs(crs), .sym(sym),
  .sym_valid(sym_valid), .dscr_sync(dscr_sync));

// file: dv/fer_line_src.sv
// Remote transmitter model: scrambles a plain stream onto three line levels.
// Assumes rx_clk is the bit clock; mode 0 quiet, 1 IDLE, 2 zero data, 3 link pulses.
`timescale 1ns/1ps
module fer_line_src (
  input wire logic rx_clk,
  input wire logic rst,
  input wire logic [1:0] mode,
  output logic [1:0] line_level
);
  logic [10:0] key_q;
  logic [1:0] ph_q;
  logic [6:0] cnt_q;
  logic key_nx;
  logic tx;
  // Key x^11+x^9+1; IDLE is all ones, pulses are two active bits in 128
  assign key_nx = key_q[10] ^ key_q[8];
  assign tx = mode == 2'h1 ? ~key_nx : mode == 2'h2 ? key_nx : mode == 2'h3 ? cnt_q < 7'h2 : 1'b0;
  // A one steps the cycle 0,+,0,-; a zero holds the level
  always_ff @(posedge rx_clk or posedge rst) begin
    if (rst) begin
      key_q <= 11'h5A3;
      ph_q <= 2'h0;
      cnt_q <= 7'h0;
    end else begin
      key_q <= {key_q[9:0], key_nx};
      ph_q <= ph_q + {1'b0, tx};
      cnt_q <= cnt_q + 7'h1;
    end
  end
  assign line_level = ph_q[0] ? {ph_q[1], 1'b1} : 2'h0;
endmodule

// file: dv/fer_rx_path_tb.sv
// Self-checking bench for the receive path.
// Assumes the line model sits on the line side; registers driven directly.
`timescale 1ns/1ps
module fer_rx_path_tb;
  logic clk = 1'b0;
  logic rx_clk = 1'b0;
  logic rst = 1'b1;
  logic [1:0] mode = 2'h0;
  fer_pkg::fer_bus_t bus = '0;
  logic [15:0] rd_data;
  logic [15:0] rv;
  logic [1:0] eq;
  logic [1:0] line_level;
  logic crs;
  logic sym_valid;
  logic dscr_sync;
  fer_pkg::fer_sym_t sym;
  int miscompares = 0;
  int n_checks = 0;
  int cyc = 0;
  int n;
  // System clock 100 MHz; line clock 80 ns, free running, phase unrelated
  always #5 clk = ~clk;
  initial #7 forever begin
    rx_clk = ~rx_clk;
    #40;
  end
  fer_line_src u_fer_line_src (.rx_clk(rx_clk), .rst(rst), .mode(mode), .line_level(line_level));
  fer_rx_path #(.HOLD_SHORT_CYC(1000), .HOLD_LONG_CYC(2500)) u_fer_rx_path (.clk(clk), .rst(rst),
    .rx_clk(rx_clk), .line_level(line_level), .bus(bus), .rd_data(rd_data), .equalizer_mode_select(eq),
    .crs(crs), .sym(sym), .sym_valid(sym_valid), .dscr_sync(dscr_sync));
  task chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk) bus.wr <= 1'b0;
    #1;
  endtask
  task rd(input logic [4:0] a);
    @(posedge clk) bus <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk) bus.rd <= 1'b0;
    #1 rv = rd_data;
  endtask
  task set_mode(input logic [1:0] m);
    @(posedge clk) mode <= m;
  endtask
  // Bounded wait for the sync flag to reach v; n holds cycles spent
  task wait_sync(input logic v, input int lim);
    n = 0;
    while (dscr_sync !== v && n < lim) begin
      @(posedge clk);
      #1 n++;
    end
  endtask
  task wait_sym;
    int k;
    k = 0;
    while (k < 200) begin
      @(posedge clk);
      #1 if (sym_valid === 1'b1) break;
      k++;
    end
    chk(16'(sym_valid), 16'h1);
  endtask
  task t_regs;
    logic [1:0] codes [3];
    codes = '{fer_pkg::EQ_ADAPTIVE, fer_pkg::EQ_OFF, fer_pkg::EQ_FIXED_MAX};
    rd(fer_pkg::ADDR_PHY_CTRL);
    chk(16'(rv[13:12]), 16'(fer_pkg::EQ_RESET));
    foreach (codes[i]) begin
      wr(fer_pkg::ADDR_PHY_CTRL, {2'h0, codes[i], 12'h0});
      chk(16'(eq), 16'(codes[i]));
      rd(fer_pkg::ADDR_PHY_CTRL);
      chk(16'(rv[13:12]), 16'(codes[i]));
    end
    rd(5'h05);
    chk(rv, 16'h0);
  endtask
  task t_pulses;
    wr(fer_pkg::ADDR_RX_CTRL, 16'h1);
    set_mode(2'h3);
    repeat (5000) @(posedge clk);
    rd(fer_pkg::ADDR_RX_STAT);
    chk(16'(rv[1]), 16'h0);
    chk(16'(crs), 16'h0);
  endtask
  task t_sync;
    set_mode(2'h1);
    wait_sync(1'b1, 8000);
    chk(16'(dscr_sync), 16'h1);
    wait_sym;
    chk(16'(sym), 16'({fer_pkg::ROUTE_DESCRAMBLED, fer_pkg::IDLE_SYM}));
    chk(16'(crs), 16'h1);
    rd(fer_pkg::ADDR_RX_STAT);
    chk(rv, 16'h0007);
    wr(fer_pkg::ADDR_RX_CTRL, 16'h0);
    @(posedge clk);
    #1 chk(16'(crs), 16'h0);
  endtask
  // Switch to data, reload by the clear bit, then time the drop
  task t_hold(input logic [15:0] cfg, input int lo, input int hi);
    wr(fer_pkg::ADDR_CODING_CFG, cfg);
    rd(fer_pkg::ADDR_CODING_CFG);
    chk(rv, cfg);
    set_mode(2'h2);
    repeat (300) @(posedge clk);
    wr(fer_pkg::ADDR_CODING_CFG, cfg | 16'h2000);
    wait_sync(1'b0, hi);
    chk(16'(n >= lo && n < hi), 16'h1);
    set_mode(2'h1);
    wait_sync(1'b1, 8000);
    chk(16'(dscr_sync), 16'h1);
  endtask
  task t_disable;
    wr(fer_pkg::ADDR_CODING_CFG, 16'h0800);
    set_mode(2'h2);
    repeat (3000) @(posedge clk);
    chk(16'(dscr_sync), 16'h1);
    wr(fer_pkg::ADDR_CODING_CFG, 16'h2000);
    wait_sync(1'b0, 1100);
    chk(16'(dscr_sync), 16'h0);
  endtask
  task t_routes;
    wr(fer_pkg::ADDR_RX_CTRL, 16'h3);
    wait_sym;
    wait_sym;
    chk(16'(sym.route), 16'(fer_pkg::ROUTE_ALIGNER));
    wr(fer_pkg::ADDR_RX_CTRL, 16'h7);
    wait_sym;
    wait_sym;
    chk(16'(sym.route), 16'(fer_pkg::ROUTE_PCS));
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Cycle ceiling well above the expected run
  always @(posedge clk) begin
    cyc++;
    if (cyc == 80000) begin
      miscompares++;
      $display("BAD t=%0t timeout", $time);
      report_and_stop;
    end
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_pulses;
    t_sync;
    t_hold(16'h0000, 990, 1100);
    t_hold(16'h1000, 2490, 2600);
    t_disable;
    t_routes;
    report_and_stop;
  end
endmodule
